// ### design/eeprom_flash_access_ctrl.sv
// data eeprom and program flash access controller
module eeprom_flash_access_ctrl (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire nvm_access_pkg::bus_s bus,
  input wire logic extResetReq,
  input wire logic wdtResetReq,
  input wire logic flashDone,
  output logic [7:0] rdData,
  output logic irq,
  output logic cpuStall,
  output nvm_access_pkg::flash_cmd_s flashCmd
);
  import nvm_access_pkg::*;

  state_s s_q;
  state_s s_d;
  logic warmReset;
  logic wrCtrl;
  logic wrSet;
  logic rdSet;
  logic finish;
  nvm_space_e space;

  assign warmReset = extResetReq | wdtResetReq;
  assign wrCtrl = bus.wr && bus.addr == OFS_CTRL;

  // space chosen from the control bits as they stand
  always_comb begin
    if (s_q.ctrl[CB_CONFIG_SPACE_SELECT]) begin
      space = SP_CONFIG;
    end else if (s_q.ctrl[CB_PGD]) begin
      space = SP_FLASH;
    end else begin
      space = SP_EEPROM;
    end
  end

  // start bits only rise from idle; write start needs both permit and key
  assign wrSet = wrCtrl && bus.wdata[CB_WR] && s_q.op == OP_IDLE
    && s_q.ctrl[CB_WRITE_PERMIT] && s_q.armed;
  assign rdSet = wrCtrl && bus.wdata[CB_RD] && s_q.op == OP_IDLE
    && !bus.wdata[CB_WR] && !s_q.ctrl[CB_PGD];

  always_comb begin
    s_d = s_q;
    finish = 1'b0;
    s_d.cmd.start = 1'b0;

    // unlock key: consecutive writes, any other write disarms
    if (bus.wr) begin
      s_d.armed = 1'b0;
      s_d.keyHalf = 1'b0;
      if (bus.addr == OFS_UNLOCK) begin
        if (bus.wdata == KEY_FIRST) begin
          s_d.keyHalf = 1'b1;
        end else if (s_q.keyHalf && bus.wdata == KEY_SECOND) begin
          s_d.armed = 1'b1;
        end
      end
    end

    // plain register writes
    if (bus.wr) begin
      unique case (bus.addr)
        OFS_CTRL: begin
          s_d.ctrl[CB_PGD] = bus.wdata[CB_PGD];
          s_d.ctrl[CB_CONFIG_SPACE_SELECT] = bus.wdata[CB_CONFIG_SPACE_SELECT];
          s_d.ctrl[CB_WRITE_PERMIT] = bus.wdata[CB_WRITE_PERMIT];
          s_d.ctrl[CB_WERR] = bus.wdata[CB_WERR];
          if (s_q.op == OP_IDLE) begin
            s_d.ctrl[CB_FREE] = bus.wdata[CB_FREE];
          end
        end
        OFS_DATA: s_d.data = bus.wdata;
        OFS_ADDR: s_d.addr = bus.wdata;
        OFS_TBLU: s_d.tblU = bus.wdata & TBLU_MASK;
        OFS_TBLH: s_d.tblH = bus.wdata;
        OFS_TBLL: s_d.tblL = bus.wdata;
        OFS_TABLE_DATA_LATCH: s_d.table_data_latch = bus.wdata;
        OFS_FLAG2: s_d.flag2 = s_q.flag2 & ~(bus.wdata & P2_MASK);
        OFS_ENA2: s_d.ena2 = bus.wdata & P2_MASK;
        OFS_PRIO2: s_d.prio2 = bus.wdata & P2_MASK;
        OFS_INTERRUPT_CONTROL: s_d.interrupt_control = bus.wdata;
        default: begin
        end
      endcase
    end

    // read start: one-cycle fetch from the array
    if (rdSet) begin
      s_d.ctrl[CB_RD] = 1'b1;
    end
    if (s_q.ctrl[CB_RD]) begin
      if (space == SP_EEPROM) begin
        s_d.data = s_q.mem[s_q.addr];
      end
      s_d.ctrl[CB_RD] = 1'b0;
    end

    // write start and the operation sequencer
    unique case (s_q.op)
      OP_IDLE: begin
        if (wrSet) begin
          s_d.ctrl[CB_WR] = 1'b1;
          if (space == SP_EEPROM) begin
            s_d.op = OP_EE_WRITE;
            s_d.timer = TMR_W'(WR_CYC - 1);
          end else begin
            s_d.op = OP_FLASH;
            s_d.stall = 1'b1;
            s_d.cmd.start = 1'b1;
            s_d.cmd.space = space;
            s_d.cmd.erase = s_q.ctrl[CB_FREE];
            s_d.cmd.ptr = {s_q.tblU[5:0], s_q.tblH, s_q.tblL};
          end
        end
      end
      OP_EE_WRITE: begin
        // erase-before-write is implicit in the overwrite
        if (s_q.timer == '0) begin
          s_d.mem[s_q.addr] = s_q.data;
          finish = 1'b1;
        end else begin
          s_d.timer = s_q.timer - 1'b1;
        end
      end
      OP_FLASH: begin
        if (flashDone) begin
          finish = 1'b1;
          s_d.stall = 1'b0;
          s_d.ctrl[CB_FREE] = 1'b0;
        end
      end
      default: s_d.op = OP_IDLE;
    endcase

    if (finish) begin
      s_d.op = OP_IDLE;
      s_d.ctrl[CB_WR] = 1'b0;
      s_d.flag2[DONE_BIT] = 1'b1;
    end

    // pin or watchdog reset: abort, flag it, wipe addr/data
    if (warmReset) begin
      if (s_q.op != OP_IDLE) begin
        s_d.ctrl[CB_WERR] = 1'b1;
      end
      s_d.data = BYTE_ZERO;
      s_d.addr = BYTE_ZERO;
      s_d.ctrl[CB_WR] = 1'b0;
      s_d.ctrl[CB_RD] = 1'b0;
      s_d.ctrl[CB_WRITE_PERMIT] = 1'b0;
      s_d.ctrl[CB_FREE] = 1'b0;
      s_d.flag2[DONE_BIT] = s_q.flag2[DONE_BIT];
      s_d.op = OP_IDLE;
      s_d.stall = 1'b0;
      s_d.cmd.start = 1'b0;
      s_d.armed = 1'b0;
      s_d.keyHalf = 1'b0;
      s_d.tblU = BYTE_ZERO;
      s_d.tblH = BYTE_ZERO;
      s_d.tblL = BYTE_ZERO;
      s_d.table_data_latch = BYTE_ZERO;
      s_d.interrupt_control = INTERRUPT_CONTROL_RST;
    end

    // read data appear the cycle after the strobe
    s_d.rdData = BYTE_ZERO;
    if (bus.rd) begin
      unique case (bus.addr)
        OFS_CTRL: s_d.rdData = s_q.ctrl & CTRL_MASK;
        OFS_UNLOCK: s_d.rdData = BYTE_ZERO;
        OFS_DATA: s_d.rdData = s_q.data;
        OFS_ADDR: s_d.rdData = s_q.addr;
        OFS_TBLU: s_d.rdData = s_q.tblU;
        OFS_TBLH: s_d.rdData = s_q.tblH;
        OFS_TBLL: s_d.rdData = s_q.tblL;
        OFS_TABLE_DATA_LATCH: s_d.rdData = s_q.table_data_latch;
        OFS_FLAG2: s_d.rdData = s_q.flag2;
        OFS_ENA2: s_d.rdData = s_q.ena2;
        OFS_PRIO2: s_d.rdData = s_q.prio2;
        OFS_INTERRUPT_CONTROL: s_d.rdData = s_q.interrupt_control;
        default: s_d.rdData = BYTE_ZERO;
      endcase
    end

    // level interrupt follows next flag and enable
    s_d.irq = |(s_d.flag2 & s_d.ena2);
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      // array content is not lost by a reset
      s_q.mem <= s_q.mem;
      s_q.ctrl <= BYTE_ZERO;
      s_q.data <= BYTE_ZERO;
      s_q.addr <= BYTE_ZERO;
      s_q.tblU <= BYTE_ZERO;
      s_q.tblH <= BYTE_ZERO;
      s_q.tblL <= BYTE_ZERO;
      s_q.table_data_latch <= BYTE_ZERO;
      s_q.flag2 <= BYTE_ZERO;
      s_q.ena2 <= BYTE_ZERO;
      s_q.prio2 <= PRIO2_RST;
      s_q.interrupt_control <= INTERRUPT_CONTROL_RST;
      s_q.keyHalf <= 1'b0;
      s_q.armed <= 1'b0;
      s_q.op <= OP_IDLE;
      s_q.timer <= '0;
      s_q.rdData <= BYTE_ZERO;
      s_q.irq <= 1'b0;
      s_q.stall <= 1'b0;
      s_q.cmd <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdData = s_q.rdData;
  assign irq = s_q.irq;
  assign cpuStall = s_q.stall;
  assign flashCmd = s_q.cmd;

  // helper: cycles spent in the eeprom write state
  logic [TMR_W:0] eeCnt;
  always_ff @(posedge sys_clk) begin
    if (!rstn || s_q.op != OP_EE_WRITE) begin
      eeCnt <= '0;
    end else begin
      eeCnt <= eeCnt + 1'b1;
    end
  end

  a_abort_flag_set: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (warmReset && s_q.op != OP_IDLE) |=> s_q.ctrl[CB_WERR])
    else $error("abort flag missing after cut write");

  a_warm_wipe: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    warmReset |=> (s_q.addr == BYTE_ZERO && s_q.data == BYTE_ZERO
      && s_q.op == OP_IDLE))
    else $error("address or data kept over warm reset");

  a_unlock_reads_zero: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (bus.rd && bus.addr == OFS_UNLOCK) |=> rdData == BYTE_ZERO)
    else $error("unlock port read not zero");

  a_write_time: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    eeCnt <= (TMR_W+1)'(WR_CYC))
    else $error("eeprom write ran past its time");

  a_no_start_locked: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (wrCtrl && bus.wdata[CB_WR] && !s_q.ctrl[CB_WR]
      && (!s_q.ctrl[CB_WRITE_PERMIT] || !s_q.armed)) |=> !s_q.ctrl[CB_WR])
    else $error("write start taken without permit or key");

  a_no_flash_read: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (s_q.ctrl[CB_PGD] && !s_q.ctrl[CB_RD]) |=> !s_q.ctrl[CB_RD])
    else $error("read start set with flash selected");

  a_done_sets_flag: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (s_q.op == OP_EE_WRITE && s_q.timer == '0 && !warmReset)
      |=> (s_q.flag2[DONE_BIT] && !s_q.ctrl[CB_WR]
        && s_q.mem[$past(s_q.addr)] == $past(s_q.data)))
    else $error("write end without flag or store");

  a_flash_stall: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (s_q.op == OP_FLASH) == cpuStall)
    else $error("stall not tied to flash operation");

  a_permit_drop: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (s_q.op == OP_EE_WRITE && s_q.timer != '0 && !warmReset)
      |=> s_q.op == OP_EE_WRITE)
    else $error("write ended early");

  a_row_erase_clear: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (s_q.op == OP_FLASH && flashDone)
      |=> (!s_q.ctrl[CB_FREE] && s_q.op == OP_IDLE)[*2])
    else $error("row erase select not cleared");

  a_rd_self_clear: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $rose(s_q.ctrl[CB_RD]) |=> !s_q.ctrl[CB_RD])
    else $error("read start not cleared by hardware");

  a_start_pulse: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    flashCmd.start |=> !flashCmd.start)
    else $error("flash start longer than one cycle");

  a_irq_level: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    irq == |(s_q.flag2 & s_q.ena2))
    else $error("interrupt level not tied to flag and enable");

  // hardware never clears the done flag on its own
  a_flag_sticky: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (s_q.flag2[DONE_BIT] && !(bus.wr && bus.addr == OFS_FLAG2
      && bus.wdata[DONE_BIT])) |=> s_q.flag2[DONE_BIT])
    else $error("done flag dropped without software clear");

  a_rd_fetch: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (s_q.ctrl[CB_RD] && space == SP_EEPROM && !warmReset)
      |=> s_q.data == $past(s_q.mem[s_q.addr]))
    else $error("read start did not fetch the array byte");

  a_wr_needs_key: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $rose(s_q.ctrl[CB_WR]) |-> $past(s_q.armed))
    else $error("write start taken without unlock key");

  a_cfg_override: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (wrSet && s_q.ctrl[CB_CONFIG_SPACE_SELECT]) |=> flashCmd.space == SP_CONFIG)
    else $error("config select did not override space");
endmodule

// ### design/nvm_access_pkg.sv
// shared constants and types for the eeprom/flash access block
package nvm_access_pkg;
  // register indices on the plain port
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_UNLOCK = 4'h1;
  localparam logic [3:0] OFS_DATA = 4'h2;
  localparam logic [3:0] OFS_ADDR = 4'h3;
  localparam logic [3:0] OFS_TBLU = 4'h4;
  localparam logic [3:0] OFS_TBLH = 4'h5;
  localparam logic [3:0] OFS_TBLL = 4'h6;
  localparam logic [3:0] OFS_TABLE_DATA_LATCH = 4'h7;
  localparam logic [3:0] OFS_FLAG2 = 4'h8;
  localparam logic [3:0] OFS_ENA2 = 4'h9;
  localparam logic [3:0] OFS_PRIO2 = 4'hA;
  localparam logic [3:0] OFS_INTERRUPT_CONTROL = 4'hB;
  // nvm_control bit positions
  localparam int CB_PGD = 7;
  localparam int CB_CONFIG_SPACE_SELECT = 6;
  localparam int CB_FREE = 4;
  localparam int CB_WERR = 3;
  localparam int CB_WRITE_PERMIT = 2;
  localparam int CB_WR = 1;
  localparam int CB_RD = 0;
  localparam logic [7:0] CTRL_MASK = 8'hDF;
  // periph flag/enable/priority layout
  localparam int DONE_BIT = 4;
  localparam logic [7:0] P2_MASK = 8'h96;
  localparam logic [7:0] PRIO2_RST = 8'h96;
  localparam logic [7:0] TBLU_MASK = 8'h3F;
  localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // unlock sequence
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // eeprom geometry
  localparam int EE_DEPTH = 256;
  // self-timed write duration
  localparam int CLK_NS = 40;
  localparam int WR_TIME_NS = 4000;
  localparam int WR_CYC = (WR_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = 8;

  typedef enum logic [1:0] {
    SP_EEPROM = 2'b00,
    SP_FLASH = 2'b01,
    SP_CONFIG = 2'b10
  } nvm_space_e;

  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_EE_WRITE = 2'b01,
    OP_FLASH = 2'b10
  } op_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_s;

  typedef struct packed {
    logic start;
    nvm_space_e space;
    logic erase;
    logic [21:0] ptr;
  } flash_cmd_s;

  typedef struct packed {
    logic [EE_DEPTH-1:0][7:0] mem;
    logic [7:0] ctrl;
    logic [7:0] data;
    logic [7:0] addr;
    logic [7:0] tblU;
    logic [7:0] tblH;
    logic [7:0] tblL;
    logic [7:0] table_data_latch;
    logic [7:0] flag2;
    logic [7:0] ena2;
    logic [7:0] prio2;
    logic [7:0] interrupt_control;
    logic keyHalf;
    logic armed;
    op_e op;
    logic [TMR_W-1:0] timer;
    logic [7:0] rdData;
    logic irq;
    logic stall;
    flash_cmd_s cmd;
  } state_s;
endpackage

// ### bench/eeprom_flash_access_ctrl_tb.sv
// self-checking bench for the eeprom/flash access controller
module eeprom_flash_access_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import nvm_access_pkg::*;
  logic sys_clk;
  logic rstn;
  bus_s bus;
  logic extResetReq;
  logic wdtResetReq;
  logic flashDone;
  logic [7:0] rdData;
  logic irq;
  logic cpuStall;
  flash_cmd_s flashCmd;
  logic rdPend;
  logic [7:0] expQ[$];
  logic [7:0] e;
  logic [7:0] v;
  logic [7:0] d0;
  logic [7:0] d1;
  int err_total;
  int checks_done;
  int cyc;
  int n;

  eeprom_flash_access_ctrl u_eeprom_flash_access_ctrl (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .bus(bus),
    .extResetReq(extResetReq),
    .wdtResetReq(wdtResetReq),
    .flashDone(flashDone),
    .rdData(rdData),
    .irq(irq),
    .cpuStall(cpuStall),
    .flashCmd(flashCmd)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmpBit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // bus tasks leave the strobe up; the next call or chk replaces it
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] x);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    expQ.push_back(x);
    @(posedge sys_clk);
  endtask

  task automatic chk(input logic ei, input logic es);
    bus <= '0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    cmpBit(irq, ei);
    cmpBit(cpuStall, es);
    @(posedge sys_clk);
  endtask

  task automatic unlock(input logic [7:0] c);
    wr(OFS_UNLOCK, KEY_FIRST);
    wr(OFS_UNLOCK, KEY_SECOND);
    wr(OFS_CTRL, c);
  endtask

  task automatic eeStart(input logic [7:0] a, input logic [7:0] d);
    wr(OFS_ADDR, a);
    wr(OFS_DATA, d);
    wr(OFS_CTRL, 8'h04);
    unlock(8'h06);
  endtask

  task automatic eeRead(input logic [7:0] a, input logic [7:0] x);
    wr(OFS_ADDR, a);
    wr(OFS_CTRL, 8'h01);
    bus <= '0;
    repeat (3) @(posedge sys_clk);
    rd(OFS_DATA, x);
    rd(OFS_CTRL, 8'h00);
  endtask

  task automatic flashOp(input logic [7:0] c, input nvm_space_e sp,
                         input logic er);
    wr(OFS_TBLU, d0);
    wr(OFS_TBLH, d1);
    wr(OFS_TBLL, d0 ^ d1);
    wr(OFS_CTRL, c);
    unlock(c | 8'h02);
    bus <= '0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (flashCmd.start !== 1'b1 && n < 8);
    cmpBit(n < 8, 1'b1);
    cmpByte(8'(flashCmd.space), 8'(sp));
    cmpBit(flashCmd.erase, er);
    cmpByte(8'(flashCmd.ptr[21:16]), d0 & TBLU_MASK);
    cmpByte(flashCmd.ptr[15:8], d1);
    cmpByte(flashCmd.ptr[7:0], d0 ^ d1);
    cmpBit(cpuStall, 1'b1);
    @(posedge sys_clk);
    rd(OFS_CTRL, c | 8'h02);
    chk(1'b0, 1'b1);
    flashDone <= 1'b1;
    @(posedge sys_clk);
    flashDone <= 1'b0;
    chk(1'b0, 1'b0);
    rd(OFS_CTRL, c & 8'hED);
    rd(OFS_FLAG2, 8'h10);
    wr(OFS_FLAG2, 8'h10);
  endtask

  function automatic logic [7:0] rwExp(input int i, input logic [7:0] w);
    case (i)
      4: return w & TBLU_MASK;
      9, 10: return w & P2_MASK;
      1, 8, 12, 13, 14, 15: return BYTE_ZERO;
      default: return w;
    endcase
  endfunction

  // read answers are matched against notes in issue order
  always @(posedge sys_clk) begin
    rdPend <= bus.rd && rstn;
  end

  always @(negedge sys_clk) begin
    if (rdPend === 1'b1 && expQ.size() > 0) begin
      e = expQ.pop_front();
      cmpByte(rdData, e);
    end else if (rstn === 1'b1) begin
      cmpByte(rdData, BYTE_ZERO);
    end
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    rstn = 1'b0;
    bus = '0;
    extResetReq = 1'b0;
    wdtResetReq = 1'b0;
    flashDone = 1'b0;
    rdPend = 1'b0;
    err_total = 0;
    checks_done = 0;
    cyc = 0;
    v = $urandom(32'hF496);
    d0 = $urandom;
    d1 = $urandom;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 16; i++) begin
      rd(4'(i), (i == 10) ? PRIO2_RST : BYTE_ZERO);
    end
    chk(1'b0, 1'b0);
    for (int i = 1; i < 16; i++) begin
      v = $urandom;
      wr(4'(i), v);
      rd(4'(i), rwExp(i, v));
    end
    wr(OFS_ENA2, 8'h00);
    // start bits refused: no permit, broken key, and read set along with write
    wr(OFS_CTRL, 8'hFF);
    rd(OFS_CTRL, 8'hDC);
    wr(OFS_CTRL, 8'h04);
    wr(OFS_UNLOCK, KEY_FIRST);
    wr(OFS_DATA, d0);
    wr(OFS_UNLOCK, KEY_SECOND);
    wr(OFS_CTRL, 8'h06);
    rd(OFS_CTRL, 8'h04);
    wr(OFS_CTRL, 8'h00);
    unlock(8'h02);
    rd(OFS_CTRL, 8'h00);
    wr(OFS_ENA2, 8'h10);
    eeStart(8'hFF, d0);
    rd(OFS_CTRL, 8'h06);
    wr(OFS_CTRL, 8'h00);
    rd(OFS_CTRL, 8'h02);
    bus <= '0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (irq !== 1'b1 && n < 300);
    @(posedge sys_clk);
    cmpBit(n >= WR_CYC - 2 && n <= WR_CYC + 5, 1'b1);
    rd(OFS_CTRL, 8'h00);
    rd(OFS_FLAG2, 8'h10);
    wr(OFS_FLAG2, 8'h10);
    rd(OFS_FLAG2, 8'h00);
    chk(1'b0, 1'b0);
    wr(OFS_ENA2, 8'h00);
    eeStart(8'h00, d1);
    bus <= '0;
    repeat (WR_CYC + 10) @(posedge sys_clk);
    rd(OFS_FLAG2, 8'h10);
    chk(1'b0, 1'b0);
    wr(OFS_ENA2, 8'h10);
    chk(1'b1, 1'b0);
    wr(OFS_FLAG2, 8'h10);
    wr(OFS_ENA2, 8'h00);
    // overwrite without erase command must land the new byte
    eeRead(8'hFF, d0);
    eeRead(8'h00, d1);
    flashOp(8'h94, SP_FLASH, 1'b1);
    flashOp(8'hC4, SP_CONFIG, 1'b0);
    for (int i = 0; i < 2; i++) begin
      eeStart(d0, d1);
      bus <= '0;
      repeat (10) @(posedge sys_clk);
      if (i == 0) begin
        extResetReq <= 1'b1;
      end else begin
        wdtResetReq <= 1'b1;
      end
      @(posedge sys_clk);
      extResetReq <= 1'b0;
      wdtResetReq <= 1'b0;
      @(posedge sys_clk);
      rd(OFS_CTRL, 8'h08);
      rd(OFS_ADDR, 8'h00);
      rd(OFS_DATA, 8'h00);
      chk(1'b0, 1'b0);
      wr(OFS_CTRL, 8'h00);
      // software rewrites the cut location and reads it back
      eeStart(d0, d1);
      bus <= '0;
      repeat (WR_CYC + 10) @(posedge sys_clk);
      eeRead(d0, d1);
      wr(OFS_FLAG2, 8'h10);
    end
    chk(1'b0, 1'b0);
    end_sim();
  end
endmodule
